// file: hw/swc_pkg.sv
// Shared constants and types for the stream write command controller
package swc_pkg;
  // Command opcode and task-file register selects
  localparam logic [7:0] SWC_CMD_CODE    = 8'h3B;
  localparam int         SWC_SEL_W       = 3;
  localparam logic [2:0] SWC_TF_OPTIONS  = 3'h0;
  localparam logic [2:0] SWC_TF_MULT     = 3'h1;
  localparam logic [2:0] SWC_TF_LEN_LOW  = 3'h2;
  localparam logic [2:0] SWC_TF_LEN_HIGH = 3'h3;
  localparam logic [2:0] SWC_TF_COMMAND  = 3'h4;

  // Option byte field positions
  localparam int SWC_OPT_EXPEDITE = 7;
  localparam int SWC_OPT_CONTINUE = 6;
  localparam int SWC_OPT_FLUSH    = 5;
  localparam int SWC_OPT_RESUME   = 4;
  localparam int SWC_OPT_SEL_HI   = 2;
  localparam int SWC_OPT_SEL_LO   = 0;
  localparam int SWC_CHAN_W       = SWC_OPT_SEL_HI - SWC_OPT_SEL_LO + 1;
  localparam int SWC_CHANNELS     = 1 << SWC_CHAN_W;

  // Error byte field positions
  localparam int SWC_ERR_OVERRUN = 0;
  localparam int SWC_ERR_REJECT  = 2;
  localparam int SWC_ERR_MISSING = 4;

  // Transfer length and address widths
  localparam int          SWC_LEN_W       = 17;
  localparam logic [16:0] SWC_MAX_SECTORS = 17'h10000;
  localparam int          SWC_LBA_W       = 48;

  // Deadline arithmetic: multiplier byte times 16-bit unit in microseconds
  localparam int          SWC_MULT_W       = 8;
  localparam int          SWC_UNIT_W       = 16;
  localparam int          SWC_DL_W         = SWC_MULT_W + SWC_UNIT_W;
  localparam logic [23:0] SWC_MIN_DL_US    = 24'h0003E8;
  localparam int          SWC_CLK_PERIOD_NS = 4;
  localparam int          SWC_US_NS         = 1000;
  localparam int          SWC_TICK_CYCLES   = SWC_US_NS / SWC_CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SWC_IDLE  = 4'h1,
    SWC_XFER  = 4'h2,
    SWC_FLUSH = 4'h4,
    SWC_DONE  = 4'h8
  } swc_state_t;
endpackage

// file: hw/swc_deadline_timer.sv
// Microsecond down-counter that enforces the command completion deadline
module swc_deadline_timer #(
  parameter int DW          = 24,
  parameter int TICK_CYCLES = 250
) (
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          reset,
  // Control
  input  wire logic          load,
  input  wire logic          arm,
  input  wire logic [DW-1:0] load_value,
  input  wire logic          stop,
  // Status
  output logic               expired
);
  localparam int PW = $clog2(TICK_CYCLES);
  localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [DW-1:0] ONE        = DW'(1);

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [DW-1:0] count;
    logic          armed;
    logic          expired;
  } swc_tmr_t;

  swc_tmr_t r;
  swc_tmr_t nxt;

  always_comb begin
    nxt = r;
    if (r.presc == PRESC_LAST) begin
      nxt.presc = '0;
    end else begin
      nxt.presc = r.presc + PW'(1);
    end
    if (load) begin
      // Prescaler restarts so the first microsecond is never short
      nxt.presc   = '0;
      nxt.count   = load_value;
      nxt.armed   = arm;
      nxt.expired = 1'b0;
    end else if (stop) begin
      nxt.armed = 1'b0;
    end else if (r.armed && r.presc == PRESC_LAST) begin
      nxt.count = r.count - ONE;
      if (r.count <= ONE) begin
        nxt.armed   = 1'b0;
        nxt.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign expired = r.expired;
endmodule

// file: hw/swc_ctrl.sv
// Stream write command decoder, sequencer and ending-status generator
module swc_ctrl
  import swc_pkg::*;
#(
  parameter logic [SWC_DL_W-1:0] MIN_DL_US   = SWC_MIN_DL_US,
  parameter int                  TICK_CYCLES = SWC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // Task-file register writes
  input  wire logic                      tf_wr,
  input  wire logic [swc_pkg::SWC_SEL_W-1:0]  tf_sel,
  input  wire logic [7:0]                tf_data,
  // Identify unit for the deadline, in microseconds
  input  wire logic [swc_pkg::SWC_UNIT_W-1:0] id_unit_us,
  // Channel default deadline configuration
  input  wire logic                      cfg_wr,
  input  wire logic [swc_pkg::SWC_CHAN_W-1:0] cfg_chan,
  input  wire logic [swc_pkg::SWC_MULT_W-1:0] cfg_default_mult,
  // Media engine handshake
  input  wire logic                      sector_done,
  input  wire logic                      sector_err,
  input  wire logic                      sector_err_reject,
  input  wire logic [swc_pkg::SWC_LBA_W-1:0]  sector_err_lba,
  input  wire logic                      flush_done,
  output logic                           xfer_active_r,
  output logic [swc_pkg::SWC_LEN_W-1:0]  xfer_count_r,
  output logic [swc_pkg::SWC_CHAN_W-1:0] chan_sel_r,
  output logic                           expedite_r,
  output logic                           resume_recovery_r,
  output logic                           flush_req_r,
  // Ending status
  output logic                           drive_occupied_r,
  output logic                           stream_error_flag_r,
  output logic                           failure_r,
  output logic [7:0]                     error_byte_r,
  output logic [swc_pkg::SWC_LBA_W-1:0]  err_lba_r,
  output logic                           intrq_r
);
  localparam logic [SWC_LEN_W-1:0] LEN_ONE = SWC_LEN_W'(1);

  typedef struct packed {
    swc_state_t                           state;
    logic [7:0]                           opts;
    logic [SWC_MULT_W-1:0]                mult;
    logic [7:0]                           len_low;
    logic [7:0]                           len_high;
    logic                                 cont;
    logic                                 flush;
    logic                                 had_err;
    logic [SWC_CHANNELS-1:0][SWC_MULT_W-1:0] cfg_mult;
    logic [SWC_CHANNELS-1:0]              cfg_valid;
    logic                                 xfer_active;
    logic [SWC_LEN_W-1:0]                 xfer_count;
    logic [SWC_CHAN_W-1:0]                chan_sel;
    logic                                 expedite;
    logic                                 resume;
    logic                                 flush_req;
    logic                                 occupied;
    logic                                 se;
    logic                                 fail;
    logic [7:0]                           err_byte;
    logic [SWC_LBA_W-1:0]                 err_lba;
    logic                                 intrq;
  } swc_ctrl_t;

  swc_ctrl_t r;
  swc_ctrl_t nxt;

  logic                  cmd_start;
  logic [SWC_CHAN_W-1:0] sel_now;
  logic [SWC_MULT_W-1:0] mult_eff;
  logic [SWC_DL_W-1:0]   dl_raw;
  logic [SWC_DL_W-1:0]   dl_us;
  logic                  dl_arm;
  logic                  dl_expired;
  logic                  timer_stop;

  assign cmd_start = tf_wr && tf_sel == SWC_TF_COMMAND && tf_data == SWC_CMD_CODE
                     && r.state == SWC_IDLE;
  assign sel_now   = r.opts[SWC_OPT_SEL_HI:SWC_OPT_SEL_LO];
  assign timer_stop = r.state == SWC_DONE;

  // Deadline selection: per-command multiplier, else channel default, else none
  always_comb begin
    mult_eff = r.mult;
    dl_arm   = 1'b1;
    if (r.mult == '0) begin
      mult_eff = r.cfg_mult[sel_now];
      dl_arm   = r.cfg_valid[sel_now] && r.cfg_mult[sel_now] != '0;
    end
    dl_raw = SWC_DL_W'(mult_eff) * SWC_DL_W'(id_unit_us);
    dl_us  = (dl_raw < MIN_DL_US) ? MIN_DL_US : dl_raw;
  end

  swc_deadline_timer #(
    .DW          (SWC_DL_W),
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .load       (cmd_start),
    .arm        (dl_arm),
    .load_value (dl_us),
    .stop       (timer_stop),
    .expired    (dl_expired)
  );

  always_comb begin
    nxt       = r;
    nxt.intrq = 1'b0;
    if (cfg_wr) begin
      nxt.cfg_mult[cfg_chan]  = cfg_default_mult;
      nxt.cfg_valid[cfg_chan] = 1'b1;
    end
    unique case (r.state)
      SWC_IDLE: begin
        // Parameter writes are held off while a command runs
        if (tf_wr) begin
          unique case (tf_sel)
            SWC_TF_OPTIONS:  nxt.opts     = tf_data;
            SWC_TF_MULT:     nxt.mult     = tf_data;
            SWC_TF_LEN_LOW:  nxt.len_low  = tf_data;
            SWC_TF_LEN_HIGH: nxt.len_high = tf_data;
            default: ;
          endcase
        end
        if (cmd_start) begin
          nxt.state       = SWC_XFER;
          nxt.occupied    = 1'b1;
          nxt.xfer_active = 1'b1;
          nxt.se          = 1'b0;
          nxt.fail        = 1'b0;
          nxt.err_byte    = '0;
          nxt.err_lba     = '0;
          nxt.had_err     = 1'b0;
          // Bit 3 of the option byte is deliberately never decoded
          nxt.expedite    = r.opts[SWC_OPT_EXPEDITE];
          nxt.cont        = r.opts[SWC_OPT_CONTINUE];
          nxt.flush       = r.opts[SWC_OPT_FLUSH];
          nxt.resume      = r.opts[SWC_OPT_RESUME];
          nxt.chan_sel    = sel_now;
          nxt.xfer_count  = {1'b0, r.len_high, r.len_low};
          if ({r.len_high, r.len_low} == 16'h0000) begin
            nxt.xfer_count = SWC_MAX_SECTORS;
          end
        end
      end
      SWC_XFER: begin
        if (dl_expired) begin
          // Expiry outranks a sector finishing in the same cycle
          nxt.err_byte[SWC_ERR_OVERRUN] = 1'b1;
          nxt.se    = r.cont;
          nxt.fail  = !r.cont;
          nxt.state = SWC_DONE;
        end else if (sector_done) begin
          nxt.xfer_count = r.xfer_count - LEN_ONE;
          if (sector_err) begin
            nxt.had_err = 1'b1;
            if (sector_err_reject) begin
              nxt.err_byte[SWC_ERR_REJECT] = 1'b1;
            end else begin
              nxt.err_byte[SWC_ERR_MISSING] = 1'b1;
            end
            if (!r.had_err) begin
              nxt.err_lba = sector_err_lba;
            end
            if (!r.cont) begin
              nxt.fail  = 1'b1;
              nxt.state = SWC_DONE;
            end
          end
          if (r.xfer_count == LEN_ONE && (r.cont || !sector_err)) begin
            nxt.se = r.had_err || sector_err;
            if (r.flush) begin
              nxt.state     = SWC_FLUSH;
              nxt.flush_req = 1'b1;
            end else begin
              nxt.state = SWC_DONE;
            end
          end
        end
      end
      SWC_FLUSH: begin
        if (dl_expired) begin
          nxt.err_byte[SWC_ERR_OVERRUN] = 1'b1;
          nxt.se        = r.cont || r.se;
          nxt.fail      = !r.cont;
          nxt.flush_req = 1'b0;
          nxt.state     = SWC_DONE;
        end else if (flush_done) begin
          nxt.flush_req = 1'b0;
          nxt.state     = SWC_DONE;
        end
      end
      SWC_DONE: begin
        // Completion interrupt marks the end of deadline timing
        nxt.intrq       = 1'b1;
        nxt.occupied    = 1'b0;
        nxt.xfer_active = 1'b0;
        nxt.flush_req   = 1'b0;
        nxt.state       = SWC_IDLE;
      end
      default: begin
        nxt.state = SWC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r       <= '0;
      r.state <= SWC_IDLE;
    end else begin
      r <= nxt;
    end
  end

  assign xfer_active_r       = r.xfer_active;
  assign xfer_count_r        = r.xfer_count;
  assign chan_sel_r          = r.chan_sel;
  assign expedite_r          = r.expedite;
  assign resume_recovery_r   = r.resume;
  assign flush_req_r         = r.flush_req;
  assign drive_occupied_r    = r.occupied;
  assign stream_error_flag_r = r.se;
  assign failure_r           = r.fail;
  assign error_byte_r        = r.err_byte;
  assign err_lba_r           = r.err_lba;
  assign intrq_r             = r.intrq;
endmodule

// file: sim/swc_ctrl_chk.sv
// Port-level assertion checker for the stream write command controller
module swc_ctrl_chk
  import swc_pkg::*;
(
  // Clock and reset
  input wire logic                           clk_sys,
  input wire logic                           reset,
  // Watched ports
  input wire logic                           tf_wr,
  input wire logic [swc_pkg::SWC_SEL_W-1:0]  tf_sel,
  input wire logic [7:0]                     tf_data,
  input wire logic                           sector_done,
  input wire logic                           flush_done,
  input wire logic                           xfer_active_r,
  input wire logic [swc_pkg::SWC_LEN_W-1:0]  xfer_count_r,
  input wire logic [swc_pkg::SWC_CHAN_W-1:0] chan_sel_r,
  input wire logic                           expedite_r,
  input wire logic                           resume_recovery_r,
  input wire logic                           flush_req_r,
  input wire logic                           drive_occupied_r,
  input wire logic                           stream_error_flag_r,
  input wire logic                           failure_r,
  input wire logic [7:0]                     error_byte_r,
  input wire logic                           intrq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] opt;
    logic [7:0] lo;
    logic [7:0] hi;
  } swc_chk_t;
  swc_chk_t st_r;
  swc_chk_t st_nxt;
  // Shadow copies of the option and length writes that an idle controller accepts
  always_comb begin
    st_nxt = st_r;
    if (tf_wr && !drive_occupied_r) begin
      if (tf_sel == SWC_TF_OPTIONS) st_nxt.opt = tf_data;
      if (tf_sel == SWC_TF_LEN_LOW) st_nxt.lo = tf_data;
      if (tf_sel == SWC_TF_LEN_HIGH) st_nxt.hi = tf_data;
    end
  end
  always_ff @(posedge clk_sys) begin
    st_r <= reset ? '0 : st_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence cmd_s;
    tf_wr && !drive_occupied_r && tf_sel == SWC_TF_COMMAND && tf_data == SWC_CMD_CODE;
  endsequence
  sequence last_s;
    xfer_active_r && sector_done && xfer_count_r == 17'h00001;
  endsequence
  cmd_start_a: assert property (cmd_s |=> drive_occupied_r && xfer_active_r && !intrq_r)
    else $error("command write did not start the transfer");
  len_load_a: assert property (cmd_s |=>
    xfer_count_r == (({st_r.hi, st_r.lo} == 16'h0000) ?
    SWC_MAX_SECTORS : {1'b0, st_r.hi, st_r.lo}))
    else $error("sector count loaded wrongly");
  opt_latch_a: assert property (cmd_s |=> chan_sel_r == st_r.opt[2:0] &&
    expedite_r == st_r.opt[7] && resume_recovery_r == st_r.opt[4])
    else $error("option bits latched wrongly");
  last_done_a: assert property (last_s ##0 !st_r.opt[5] |-> ##2 intrq_r)
    else $error("no completion two cycles after last sector");
  flush_hold_a: assert property (last_s ##0 st_r.opt[5] |=> flush_req_r && !intrq_r)
    else $error("flush not requested before completion");
  flush_end_a: assert property (flush_req_r && flush_done |=> !flush_req_r ##1 intrq_r)
    else $error("flush completion not followed by interrupt");
  end_idle_a: assert property (intrq_r |-> !drive_occupied_r && !xfer_active_r ##1 !intrq_r)
    else $error("completion while still occupied");
  cont_end_a: assert property (intrq_r && st_r.opt[6] && error_byte_r != 8'h00 |->
    stream_error_flag_r && !failure_r)
    else $error("continue mode ending status wrong");
  stop_end_a: assert property (intrq_r && !st_r.opt[6] && error_byte_r != 8'h00 |->
    failure_r && !stream_error_flag_r)
    else $error("stopping mode ending status wrong");
endmodule

bind swc_ctrl swc_ctrl_chk u_chk (.clk_sys(clk_sys), .reset(reset), .tf_wr(tf_wr),
  .tf_sel(tf_sel), .tf_data(tf_data), .sector_done(sector_done), .flush_done(flush_done),
  .xfer_active_r(xfer_active_r), .xfer_count_r(xfer_count_r), .chan_sel_r(chan_sel_r),
  .expedite_r(expedite_r), .resume_recovery_r(resume_recovery_r), .flush_req_r(flush_req_r),
  .drive_occupied_r(drive_occupied_r), .stream_error_flag_r(stream_error_flag_r),
  .failure_r(failure_r), .error_byte_r(error_byte_r), .intrq_r(intrq_r));

// file: sim/swc_media_model.sv
// Behavioural media engine answering sector and flush requests
module swc_media_model
  import swc_pkg::*;
(
  // Clock and controller requests
  input  wire logic                          clk_sys,
  input  wire logic                          xfer_active_r,
  input  wire logic                          flush_req_r,
  // Bench control: idle cycles per answer, erroring sector (FF none)
  input  wire logic [7:0]                    gap,
  input  wire logic [7:0]                    err_at,
  input  wire logic                          rej,
  input  wire logic [swc_pkg::SWC_LBA_W-1:0] lba,
  // Answers
  output logic                               sector_done,
  output logic                               sector_err,
  output logic                               sector_err_reject,
  output logic [swc_pkg::SWC_LBA_W-1:0]      sector_err_lba,
  output logic                               flush_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_c = 8'h00;
  logic [7:0] sec_n = 8'h00;
  initial begin
    {sector_done, sector_err, sector_err_reject, flush_done} = 4'h0;
    sector_err_lba = 48'h0;
  end
  always @(negedge clk_sys) begin
    sector_done <= 1'b0;
    sector_err <= 1'b0;
    flush_done <= 1'b0;
    // Unqualified error fields toggle so a stale value is never trusted
    sector_err_reject <= ~sector_err_reject;
    sector_err_lba <= ~sector_err_lba;
    if (!xfer_active_r) begin
      wait_c <= 8'h00;
      sec_n <= 8'h00;
    end else if (wait_c != gap) begin
      wait_c <= wait_c + 8'h01;
    end else begin
      wait_c <= 8'h00;
      if (flush_req_r) begin
        flush_done <= 1'b1;
      end else begin
        sector_done <= 1'b1;
        sec_n <= sec_n + 8'h01;
        // The counter wraps on long commands, so FF must never match
        if (sec_n == err_at && err_at != 8'hFF) begin
          sector_err <= 1'b1;
          sector_err_reject <= rej;
          sector_err_lba <= lba;
        end
      end
    end
  end
endmodule

// file: sim/swc_ctrl_test.sv
// Self-checking bench for the stream write command controller
module swc_ctrl_test;
  import swc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        tf_wr = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [2:0]  tf_sel = 3'h0;
  logic [2:0]  cfg_chan = 3'h0;
  logic [7:0]  tf_data = 8'h00;
  logic [7:0]  cfg_default_mult = 8'h00;
  logic [15:0] id_unit_us = 16'h0000;
  logic [7:0]  m_gap = 8'h02;
  logic [7:0]  m_err_at = 8'hFF;
  logic        m_rej = 1'b0;
  logic [47:0] m_lba = 48'h0;
  logic        sector_done, sector_err, sector_err_reject, flush_done;
  logic        xfer_active_r, expedite_r, resume_recovery_r, flush_req_r, intrq_r;
  logic        drive_occupied_r, stream_error_flag_r, failure_r;
  logic [47:0] sector_err_lba, err_lba_r;
  logic [16:0] xfer_count_r;
  logic [2:0]  chan_sel_r;
  logic [7:0]  error_byte_r;
  wire  [57:0] end_got = {stream_error_flag_r, failure_r, error_byte_r, err_lba_r};
  logic [57:0] exp_q[$];
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 21;
  always #2 clk_sys = ~clk_sys;
  // Minimum deadline lowered to 20 us so the raise is visible in short runs
  swc_ctrl #(.MIN_DL_US(24'h000014), .TICK_CYCLES(2)) dut (.clk_sys(clk_sys), .reset(reset),
    .tf_wr(tf_wr), .tf_sel(tf_sel), .tf_data(tf_data), .id_unit_us(id_unit_us),
    .cfg_wr(cfg_wr), .cfg_chan(cfg_chan), .cfg_default_mult(cfg_default_mult),
    .sector_done(sector_done), .sector_err(sector_err), .sector_err_reject(sector_err_reject),
    .sector_err_lba(sector_err_lba), .flush_done(flush_done), .xfer_active_r(xfer_active_r),
    .xfer_count_r(xfer_count_r), .chan_sel_r(chan_sel_r), .expedite_r(expedite_r),
    .resume_recovery_r(resume_recovery_r), .flush_req_r(flush_req_r),
    .drive_occupied_r(drive_occupied_r), .stream_error_flag_r(stream_error_flag_r),
    .failure_r(failure_r), .error_byte_r(error_byte_r), .err_lba_r(err_lba_r),
    .intrq_r(intrq_r));
  swc_media_model media (.clk_sys(clk_sys), .xfer_active_r(xfer_active_r),
    .flush_req_r(flush_req_r), .gap(m_gap), .err_at(m_err_at), .rej(m_rej), .lba(m_lba),
    .sector_done(sector_done), .sector_err(sector_err), .sector_err_reject(sector_err_reject),
    .sector_err_lba(sector_err_lba), .flush_done(flush_done));
  task automatic tally(input bit bad, input string what);
    comparisons++;
    if (bad) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic chk_launch(input logic [21:0] got, input logic [21:0] exp);
    tally(got !== exp, "latched command fields differ");
  endtask
  task automatic chk_end(input logic [57:0] got, input logic [57:0] exp);
    tally(got !== exp, "ending status differs");
  endtask
  task automatic results;
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tfw(input logic [2:0] sel, input logic [7:0] data);
    @(negedge clk_sys);
    tf_wr = 1'b1;
    tf_sel = sel;
    tf_data = data;
  endtask
  // One whole command; st holds expected {stream error, failure, error byte}
  task automatic run(input logic [7:0] opt, mult, input logic [15:0] len, unit,
                     input logic [7:0] gap, err_at, input logic rej, input logic [9:0] st);
    logic [63:0] r64;
    logic [16:0] cnt;
    int          n;
    r64 = {$random(seed), $random(seed)};
    m_lba = r64[47:0];
    m_gap = gap;
    m_err_at = err_at;
    m_rej = rej;
    id_unit_us = unit;
    cnt = (len == 16'h0000) ? SWC_MAX_SECTORS : {1'b0, len};
    tfw(SWC_TF_OPTIONS, opt);
    tfw(SWC_TF_MULT, mult);
    tfw(SWC_TF_LEN_LOW, len[7:0]);
    tfw(SWC_TF_LEN_HIGH, len[15:8]);
    tfw(SWC_TF_COMMAND, SWC_CMD_CODE);
    exp_q.push_back({st, (err_at != 8'hFF) ? m_lba : 48'h0});
    @(negedge clk_sys);
    tf_wr = 1'b0;
    chk_launch({chan_sel_r, expedite_r, resume_recovery_r, xfer_count_r},
               {opt[2:0], opt[7], opt[4], cnt});
    n = 0;
    while (drive_occupied_r !== 1'b0 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 5000) tally(1'b1, "command never completed");
    repeat (2) @(negedge clk_sys);
  endtask
  always @(negedge clk_sys) begin
    if (intrq_r === 1'b1) begin
      if (exp_q.size() == 0) begin
        tally(1'b1, "unexpected completion");
      end else begin
        chk_end(end_got, exp_q.pop_front());
      end
    end
  end
  initial begin
    #100000;
    tally(1'b1, "watchdog expired");
    results();
  end
  initial begin
    logic [31:0] r;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    cfg_wr = 1'b1;
    cfg_chan = 3'h3;
    cfg_default_mult = 8'h02;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
    r = $random(seed);
    run((r[7:0] & 8'h9F) | 8'h08, 8'hFF, 16'h0102, 16'h0004, 8'h02, 8'hFF, 1'b0, 10'h000);
    for (int k = 0; k < 2; k++) begin
      run(8'h41, 8'hFF, 16'h0003, 16'h0004, 8'h02, 8'h01, k[0],
          {2'b10, k[0] ? 8'h04 : 8'h10});
    end
    run(8'h00, 8'hFF, 16'h0004, 16'h0004, 8'h02, 8'h00, 1'b0, {2'b01, 8'h10});
    run(8'h25, 8'hFF, 16'h0001, 16'h0004, 8'h03, 8'hFF, 1'b0, 10'h000);
    run(8'hC2, 8'h05, 16'h0000, 16'h0004, 8'h02, 8'hFF, 1'b0, {2'b10, 8'h01});
    run(8'h03, 8'h00, 16'h0000, 16'h0004, 8'h02, 8'hFF, 1'b0, {2'b01, 8'h01});
    run(8'h06, 8'h00, 16'h0003, 16'h0004, 8'h1E, 8'hFF, 1'b0, 10'h000);
    run(8'h40, 8'h01, 16'h0003, 16'h0001, 8'h04, 8'hFF, 1'b0, 10'h000);
    results();
  end
endmodule
